// ---- verilog/adc_window_map.svh ----
// register addresses, field positions and reset values of the result and window block
// assumes an 8-bit special-function register bus with a byte address
`ifndef ADC_WINDOW_MAP_SVH
`define ADC_WINDOW_MAP_SVH
`define ADDR_CONTROL 8'he8
`define ADDR_RESULT_LOW 8'hbe
`define ADDR_RESULT_HIGH 8'hbf
`define ADDR_UPPER_LOW 8'hc4
`define ADDR_UPPER_HIGH 8'hc5
`define ADDR_LOWER_LOW 8'hc6
`define ADDR_LOWER_HIGH 8'hc7
`define BIT_LEFT_JUSTIFY 0
`define BIT_WINDOW_FLAG 1
`define RESET_BYTE_ONES 8'hff
`define RESET_BYTE_ZERO 8'h00
`define RESET_CONTROL_LOW 2'h0
`define RESET_CONTROL_HIGH 6'h00
`define RESET_WORD_ZERO 12'h000
`define RESET_WORD_ONES 12'hfff
`define RESET_BIT_ZERO 1'b0
`define CONTROL_STORE_HIGH 7
`define CONTROL_STORE_LOW 2
`endif

// ---- verilog/adc_window_pkg.sv ----
// types shared by the result and window block
// assumes nothing beyond the register map header
package adc_window_pkg;
   typedef logic [7:0] byte_type;
   typedef logic [11:0] word_type;
endpackage : adc_window_pkg

// ---- verilog/adc_result_window_detector.sv ----
// result byte registers, limit words and window comparator of the 12-bit converter
// assumes a single-cycle sfr bus and a result strobe from the converter core, both on MCLK
`timescale 1ns/100ps
`include "adc_window_map.svh"

// Notes on behaviour
// - every new result compared without software
// - window match sets flag in control register
// - flag always readable for polling
// - each limit word has high/low bytes
// - flag for inside or outside window
module adc_result_window_detector (
   // clock and reset
   input wire logic MCLK,
   input wire logic RSTN,
   // special-function register bus
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   output logic SFR_HIT,
   // converter core
   input wire logic RESULT_VALID,
   input wire logic [11:0] RESULT_DATA,
   // status out
   output logic WINDOW_EVENT,
   output logic WINDOW_FLAG
);
   adc_window_pkg::byte_type result_high_reg, result_low_reg;
   adc_window_pkg::byte_type upper_high_reg, upper_low_reg, lower_high_reg, lower_low_reg;
   logic [5:0] control_upper_reg;
   logic left_justify_select_reg;
   logic window_compare_flag_reg;
   logic window_event_reg;
   adc_window_pkg::word_type upper_word, lower_word;
   logic match;
   logic wr_control;
   logic wr_rhigh;
   logic wr_rlow;
   logic wr_uhigh;
   logic wr_ulow;
   logic wr_lhigh;
   logic wr_llow;

   // a 12-bit limit is taken from the same justification as the result
   function automatic adc_window_pkg::word_type join_word(input adc_window_pkg::byte_type hi,
      input adc_window_pkg::byte_type lo, input logic left);
      if (left) begin
         join_word = {hi, lo[7:4]};
      end else begin
         join_word = {hi[3:0], lo};
      end
   endfunction : join_word

   assign upper_word = join_word(upper_high_reg, upper_low_reg, left_justify_select_reg);
   assign lower_word = join_word(lower_high_reg, lower_low_reg, left_justify_select_reg);

   // strict compare; the relative order of the two limits picks inside or outside
   function automatic logic in_window(input adc_window_pkg::word_type r,
      input adc_window_pkg::word_type up, input adc_window_pkg::word_type lo);
      if (lo > up) begin
         in_window = (r > up) && (r < lo);
      end else begin
         in_window = (r > up) || (r < lo);
      end
   endfunction : in_window

   // true when a bus write targets the given register
   function automatic logic write_to(input logic wr, input logic [7:0] addr, input logic [7:0] target);
      write_to = wr && (addr == target);
   endfunction : write_to

   // true for every mapped register address
   function automatic logic is_mapped(input logic [7:0] addr);
      case (addr)
         `ADDR_CONTROL, `ADDR_RESULT_HIGH, `ADDR_RESULT_LOW: begin
            is_mapped = 1'b1;
         end
         `ADDR_UPPER_HIGH, `ADDR_UPPER_LOW, `ADDR_LOWER_HIGH, `ADDR_LOWER_LOW: begin
            is_mapped = 1'b1;
         end
         default: begin
            is_mapped = 1'b0;
         end
      endcase
   endfunction : is_mapped

   assign match = in_window(RESULT_DATA, upper_word, lower_word);

   assign wr_control = write_to(SFR_WR, SFR_ADDR, `ADDR_CONTROL);
   assign wr_rhigh = write_to(SFR_WR, SFR_ADDR, `ADDR_RESULT_HIGH);
   assign wr_rlow = write_to(SFR_WR, SFR_ADDR, `ADDR_RESULT_LOW);
   assign wr_uhigh = write_to(SFR_WR, SFR_ADDR, `ADDR_UPPER_HIGH);
   assign wr_ulow = write_to(SFR_WR, SFR_ADDR, `ADDR_UPPER_LOW);
   assign wr_lhigh = write_to(SFR_WR, SFR_ADDR, `ADDR_LOWER_HIGH);
   assign wr_llow = write_to(SFR_WR, SFR_ADDR, `ADDR_LOWER_LOW);

   // justification select and spare storage bits of the control register
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         control_upper_reg <= `RESET_CONTROL_HIGH;
         left_justify_select_reg <= `RESET_BIT_ZERO;
      end else if (wr_control) begin
         control_upper_reg <= SFR_WDATA[`CONTROL_STORE_HIGH:`CONTROL_STORE_LOW];
         left_justify_select_reg <= SFR_WDATA[`BIT_LEFT_JUSTIFY];
      end
   end

   // window flag; a hardware set wins over a software clear in the same cycle
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         window_compare_flag_reg <= `RESET_BIT_ZERO;
      end else if (RESULT_VALID && match) begin
         window_compare_flag_reg <= 1'b1;
      end else if (wr_control) begin
         window_compare_flag_reg <= SFR_WDATA[`BIT_WINDOW_FLAG];
      end
   end

   // one-cycle request toward the interrupt logic
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         window_event_reg <= `RESET_BIT_ZERO;
      end else begin
         window_event_reg <= RESULT_VALID && match;
      end
   end

   // result high byte; a new result wins over a software write
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         result_high_reg <= `RESET_BYTE_ZERO;
      end else if (RESULT_VALID) begin
         if (left_justify_select_reg) begin
            result_high_reg <= RESULT_DATA[11:4];
         end else begin
            result_high_reg <= {4'h0, RESULT_DATA[11:8]};
         end
      end else if (wr_rhigh) begin
         result_high_reg <= SFR_WDATA;
      end
   end

   // result low byte; the spare nibble reads as zero when left justified
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         result_low_reg <= `RESET_BYTE_ZERO;
      end else if (RESULT_VALID) begin
         if (left_justify_select_reg) begin
            result_low_reg <= {RESULT_DATA[3:0], 4'h0};
         end else begin
            result_low_reg <= RESULT_DATA[7:0];
         end
      end else if (wr_rlow) begin
         result_low_reg <= SFR_WDATA;
      end
   end

   // upper limit high byte
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         upper_high_reg <= `RESET_BYTE_ONES;
      end else if (wr_uhigh) begin
         upper_high_reg <= SFR_WDATA;
      end
   end

   // upper limit low byte
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         upper_low_reg <= `RESET_BYTE_ONES;
      end else if (wr_ulow) begin
         upper_low_reg <= SFR_WDATA;
      end
   end

   // lower limit high byte
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         lower_high_reg <= `RESET_BYTE_ZERO;
      end else if (wr_lhigh) begin
         lower_high_reg <= SFR_WDATA;
      end
   end

   // lower limit low byte
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         lower_low_reg <= `RESET_BYTE_ZERO;
      end else if (wr_llow) begin
         lower_low_reg <= SFR_WDATA;
      end
   end

   // address decode flag, independent of the read enable
   assign SFR_HIT = is_mapped(SFR_ADDR);

   // read mux, combinational; reads zero while the read enable is low
   always_comb begin
      case (SFR_ADDR)
         `ADDR_CONTROL: SFR_RDATA = {control_upper_reg, window_compare_flag_reg, left_justify_select_reg};
         `ADDR_RESULT_HIGH: SFR_RDATA = result_high_reg;
         `ADDR_RESULT_LOW: SFR_RDATA = result_low_reg;
         `ADDR_UPPER_HIGH: SFR_RDATA = upper_high_reg;
         `ADDR_UPPER_LOW: SFR_RDATA = upper_low_reg;
         `ADDR_LOWER_HIGH: SFR_RDATA = lower_high_reg;
         `ADDR_LOWER_LOW: SFR_RDATA = lower_low_reg;
         default: begin
            SFR_RDATA = `RESET_BYTE_ZERO;
         end
      endcase
      if (!SFR_RD) begin
         SFR_RDATA = `RESET_BYTE_ZERO;
      end
   end

   assign WINDOW_EVENT = window_event_reg;
   assign WINDOW_FLAG = window_compare_flag_reg;
endmodule : adc_result_window_detector

// ---- dv/adc_window_chk.sv ----
// checker for the window block; bound to the detector's top ports
`timescale 1ns/100ps
module adc_window_chk (input wire logic MCLK, RSTN, SFR_WR, SFR_RD, SFR_HIT, RESULT_VALID, WINDOW_EVENT, WINDOW_FLAG,
   input wire logic [7:0] SFR_ADDR, SFR_RDATA);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   a_event_cause: assert property (WINDOW_EVENT |-> $past(RESULT_VALID) && WINDOW_FLAG)
      else $error("event without result");
   a_event_pulse: assert property (WINDOW_EVENT && !RESULT_VALID |=> !WINDOW_EVENT)
      else $error("event too long");
   a_flag_poll: assert property (SFR_RD && SFR_ADDR == 8'he8 |-> SFR_RDATA[1] == WINDOW_FLAG)
      else $error("flag read mismatch");
   a_flag_held: assert property ($fell(WINDOW_FLAG) |-> $past(SFR_WR) && $past(SFR_ADDR) == 8'he8)
      else $error("flag lost");
   a_flag_rise: assert property ($rose(WINDOW_FLAG) |->
      $past(RESULT_VALID) || ($past(SFR_WR) && $past(SFR_ADDR) == 8'he8))
      else $error("flag set without cause");
   a_limit_mapped: assert property (SFR_ADDR >= 8'hc4 && SFR_ADDR <= 8'hc7 |-> SFR_HIT)
      else $error("limit byte not mapped");
   cover property (WINDOW_EVENT);
   cover property ($fell(WINDOW_FLAG));
   cover property (SFR_RD && SFR_ADDR == 8'he8);
endmodule : adc_window_chk
bind adc_result_window_detector adc_window_chk adc_window_chk_i (.*);

// ---- dv/adc_core_model.sv ----
// converter core model: one-cycle result strobes on MCLK, stale data inverted
`timescale 1ns/100ps
module adc_core_model (input wire logic MCLK, output logic RESULT_VALID = 1'h0, output logic [11:0] RESULT_DATA = 12'h000);
   task send(input logic [11:0] d);
      @(posedge MCLK);
      {RESULT_VALID, RESULT_DATA} <= {1'h1, d};
      @(posedge MCLK);
      {RESULT_VALID, RESULT_DATA} <= {1'h0, ~d};
   endtask : send
endmodule : adc_core_model

// ---- dv/tb_top.sv ----
// bench for the window block; register bus tasks, results from the core model
`timescale 1ns/100ps
module tb_top;
   logic MCLK = 1'h0, RSTN = 1'h0, SFR_WR = 1'h0, SFR_RD = 1'h0, SFR_HIT, RESULT_VALID, WINDOW_EVENT, WINDOW_FLAG;
   logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
   logic [11:0] RESULT_DATA;
   int errors = 0, checked = 0;
   always #12.5 MCLK = ~MCLK;
   adc_core_model adc_core_model_i (.*);
   adc_result_window_detector adc_result_window_detector_i (.*);
   task chk(input string n, input logic [7:0] e, g);
      checked++;
      errors += (g !== e);
      if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
   endtask : chk
   task wr(input logic [7:0] a, d);
      @(posedge MCLK) {SFR_ADDR, SFR_WDATA, SFR_WR} <= {a, d, 1'h1};
      @(posedge MCLK) SFR_WR <= 1'h0;
   endtask : wr
   task rd(input logic [7:0] a, e);
      @(posedge MCLK) {SFR_ADDR, SFR_RD} <= {a, 1'h1};
      #1 chk("read", e, SFR_RDATA);
   endtask : rd
   task conv(input logic [11:0] d, input logic e);
      adc_core_model_i.send(d);
      #1 chk("event", {7'h00, e}, {7'h00, WINDOW_EVENT});
   endtask : conv
   task print_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (12) @(posedge MCLK);
      RSTN <= 1'h1;
      rd(8'hc4, 8'hff);
      rd(8'h00, 8'h00);
      chk("hit", 8'h00, {7'h00, SFR_HIT});
      wr(8'he8, 8'h01);
      conv(12'habc, 1'h0);
      rd(8'hbf, 8'hab);
      rd(8'hbe, 8'hc0);
      $display("test 1 done");
      for (int m = 0; m < 2; m++) begin
         wr(8'he8, 8'h00);
         for (int b = 0; b < 4; b++) wr(8'hc4 + 8'(b), 8'((m ? 32'h01000050 : 32'h00500100) >> 8 * b));
         conv(12'h080, m[0]);
         conv(12'h200, !m[0]);
         conv(12'h100, 1'h0);
         chk("flag", 8'h01, {7'h00, WINDOW_FLAG});
         rd(8'he8, 8'h02);
         $display("test %0d done", m + 2);
      end
      rd(8'hbf, 8'h01);
      rd(8'hbe, 8'h00);
      wr(8'he8, 8'h00);
      rd(8'he8, 8'h00);
      print_verdict;
   end
endmodule : tb_top
